// ### rtl/program_sequencer_core_cfg.svh
/*
 * Constants of the program sequencer core: register offsets, field
 * positions, reset values, opcodes and stack depth.
 * Assumes it is included once per compile unit by its bare name.
 */
`ifndef PROGRAM_SEQUENCER_CORE_CFG_SVH
`define PROGRAM_SEQUENCER_CORE_CFG_SVH

`define PSC_PC_W 12
`define PSC_STACK_DEPTH 3'h6
`define PSC_RESET_PC 12'h000
`define PSC_INT_VECTOR 12'h004

`define PSC_ADDR_PC_LOW 8'h00
`define PSC_ADDR_CTRL 8'h04
`define PSC_ADDR_STATUS 8'h08

`define PSC_CTRL_RUN 0
`define PSC_CTRL_IEN 1
`define PSC_CTRL_RESET 1'h1

`define PSC_OPC_NOP 4'h0
`define PSC_OPC_ALU 4'h1
`define PSC_OPC_ALUP 4'h2
`define PSC_OPC_JUMP 4'h3
`define PSC_OPC_CALL 4'h4
`define PSC_OPC_RETURN 4'h5
`define PSC_OPC_IRETURN 4'h6
`define PSC_OPC_SKIP 4'h7
`define PSC_OPC_XALU 4'h9

`define PSC_ALU_ADD 4'h0
`define PSC_ALU_ADC 4'h1
`define PSC_ALU_SUB 4'h2
`define PSC_ALU_SBC 4'h3
`define PSC_ALU_DAA 4'h4
`define PSC_ALU_AND 4'h5
`define PSC_ALU_OR 4'h6
`define PSC_ALU_XOR 4'h7
`define PSC_ALU_CPL 4'h8
`define PSC_ALU_RR 4'h9
`define PSC_ALU_RRC 4'ha
`define PSC_ALU_RL 4'hb
`define PSC_ALU_RLC 4'hc
`define PSC_ALU_INC 4'hd
`define PSC_ALU_DEC 4'he
`define PSC_ALU_LD 4'hf

`endif

// ### rtl/program_sequencer_core_pkg.sv
/*
 * Types of the program sequencer core: phases, bus carriers and state.
 * Assumes the cfg header is compiled alongside.
 */
package program_sequencer_core_pkg;

	typedef enum logic [1:0] {
		PH_T1 = 2'h0,
		PH_T2 = 2'h1,
		PH_T3 = 2'h3,
		PH_T4 = 2'h2
	} phase_t;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} apb_rsp_t;

	typedef struct packed {
		phase_t phase;
		logic [11:0] pc;
		logic [11:0] prog_addr;
		logic [15:0] fetch;
		logic fetch_v;
		logic [15:0] ir;
		logic ir_v;
		logic ext;
		logic [7:0] acc;
		logic c;
		logic z;
		logic ac;
		logic ov;
		logic [5:0][11:0] stk;
		logic [2:0] sp;
		logic pend;
		logic ien;
		logic run;
		logic pclw;
		logic [7:0] pclv;
		logic [31:0] rdata;
		logic ack;
	} seq_state_t;

endpackage

// ### rtl/program_sequencer_core.sv
/*
 * Instruction sequencing core: four-phase cycle, fetch/execute overlap,
 * 12-bit program counter, six-level return stack, 8-bit ALU, APB slave.
 * Assumes program memory answers combinationally within one phase and
 * the interrupt logic sits on pclk.
 */
`timescale 1ns/1ps
`include "program_sequencer_core_cfg.svh"

// Notes on behaviour
// - Clock is split into four phases; one pass is one instruction cycle.
// - Program counter steps on entering first phase; that phase fetches.
// - Phases two to four decode and execute the previously fetched word.
// - Fetch overlaps execution, so plain instructions complete one per cycle.
// - Standard takes one cycle, extended two, counter changes add one.
// - Jump or call: one cycle for the target, one for the branch.
// - The ALU works on 8-bit operands through the accumulator.
// - Program counter is 12 bits: 4-bit high part, 8-bit low byte.
// - Only the low byte is reachable by software.
// - Writing the low byte jumps within the current 256-word page.
// - A low-byte write inserts one dummy cycle for the prefetch.
// - A met skip discards the fetched word and runs a dummy cycle.
// - Jump, call, interrupt and reset load the target directly.
// - Six-entry stack is invisible to software; the pointer reads back in status.
// - Call and interrupt acknowledge push the current fetch address.
// - Return and interrupt return pop and restore the counter.
// - Reset sets the stack pointer to zero, the empty stack.
// - Full stack holds the interrupt pending until a return pops.
// - Call on a full stack still runs and loses the oldest entry.
// - ALU results go to the destination and update status flags.
// - ALU does add, subtract, carry forms, decimal adjust, logic, rotates.
// - Reset starts execution at address zero.
module program_sequencer_core (
	input wire logic pclk,
	input wire logic presetn,
	input wire program_sequencer_core_pkg::apb_req_t apb_req,
	output program_sequencer_core_pkg::apb_rsp_t apb_rsp,
	output logic [11:0] prog_addr,
	input wire logic [15:0] prog_rdata,
	input wire logic int_req,
	output logic int_ack
);
	import program_sequencer_core_pkg::*;

	seq_state_t s_q;
	seq_state_t s_d;
	logic [3:0] opc;
	logic [3:0] fn;
	logic [7:0] imm;
	logic [7:0] bb;
	logic cin;
	logic [8:0] sum;
	logic [4:0] half;
	logic [7:0] res;
	logic [8:0] daa;
	logic rc;
	logic rac;
	logic rov;
	logic is_alu;
	logic branch;
	logic flush;
	logic [11:0] tgt;
	logic [11:0] push_val;
	logic do_push;
	logic do_pop;
	logic take_int;
	logic [2:0] sp_m1;
	logic wr_acc;
	logic rd_acc;
	logic unmapped;

	//////////////////////////////////////////////////////////////////////
	always_comb begin
		s_d = s_q;
		s_d.ack = 1'b0;
		opc = s_q.ir[15:12];
		fn = s_q.ir[11:8];
		imm = s_q.ir[7:0];
		branch = 1'b0;
		flush = 1'b0;
		tgt = s_q.pc;
		push_val = s_q.prog_addr;
		do_push = 1'b0;
		do_pop = 1'b0;
		take_int = 1'b0;
		sp_m1 = s_q.sp - 3'h1;
		is_alu = 1'b0;
		// All eight-bit operations pass through the accumulator.
		bb = imm;
		cin = 1'b0;
		if (fn == `PSC_ALU_SUB || fn == `PSC_ALU_SBC) begin
			bb = ~imm;
		end
		if (fn == `PSC_ALU_ADC || fn == `PSC_ALU_SBC) begin
			cin = s_q.c;
		end else if (fn == `PSC_ALU_SUB) begin
			cin = 1'b1;
		end
		sum = {1'b0, s_q.acc} + {1'b0, bb} + {8'h00, cin};
		half = {1'b0, s_q.acc[3:0]} + {1'b0, bb[3:0]} + {4'h0, cin};
		daa = {1'b0, s_q.acc};
		if (s_q.acc[3:0] > 4'h9 || s_q.ac) begin
			daa = daa + 9'h006;
		end
		if (daa[7:4] > 4'h9 || s_q.c || daa[8]) begin
			daa = daa + 9'h060;
		end
		res = sum[7:0];
		rc = s_q.c;
		rac = s_q.ac;
		rov = s_q.ov;
		case (fn)
			`PSC_ALU_ADD, `PSC_ALU_ADC, `PSC_ALU_SUB, `PSC_ALU_SBC: begin
				rc = sum[8];
				rac = half[4];
				rov = (s_q.acc[7] == bb[7]) && (sum[7] != s_q.acc[7]);
			end
			`PSC_ALU_DAA: begin
				res = daa[7:0];
				rc = daa[8] | s_q.c;
			end
			`PSC_ALU_AND: res = s_q.acc & imm;
			`PSC_ALU_OR: res = s_q.acc | imm;
			`PSC_ALU_XOR: res = s_q.acc ^ imm;
			`PSC_ALU_CPL: res = ~s_q.acc;
			`PSC_ALU_RR: res = {s_q.acc[0], s_q.acc[7:1]};
			`PSC_ALU_RRC: begin
				res = {s_q.c, s_q.acc[7:1]};
				rc = s_q.acc[0];
			end
			`PSC_ALU_RL: res = {s_q.acc[6:0], s_q.acc[7]};
			`PSC_ALU_RLC: begin
				res = {s_q.acc[6:0], s_q.c};
				rc = s_q.acc[7];
			end
			`PSC_ALU_INC: res = s_q.acc + 8'h01;
			`PSC_ALU_DEC: res = s_q.acc - 8'h01;
			`PSC_ALU_LD: res = imm;
			default: res = sum[7:0];
		endcase

		// Phases advance on every edge whether or not the core runs.
		case (s_q.phase)
			PH_T1: s_d.phase = PH_T2;
			PH_T2: s_d.phase = PH_T3;
			PH_T3: s_d.phase = PH_T4;
			PH_T4: s_d.phase = PH_T1;
			default: s_d.phase = PH_T1;
		endcase

		if (s_q.run && s_q.phase == PH_T1) begin
			s_d.fetch = prog_rdata;
			s_d.fetch_v = 1'b1;
		end

		// Execution lands on the last phase edge.
		if (s_q.run && s_q.phase == PH_T4) begin
			if (s_q.ir_v && opc == `PSC_OPC_XALU && !s_q.ext) begin
				// First cycle of an extended operation holds the pipe.
				s_d.ext = 1'b1;
			end else begin
				s_d.ext = 1'b0;
				if (s_q.ir_v) begin
					case (opc)
						`PSC_OPC_ALU, `PSC_OPC_XALU: is_alu = 1'b1;
						`PSC_OPC_ALUP: begin
							is_alu = 1'b1;
							branch = 1'b1;
							tgt = {s_q.pc[11:8], res};
						end
						`PSC_OPC_JUMP: begin
							branch = 1'b1;
							tgt = s_q.ir[11:0];
						end
						`PSC_OPC_CALL: begin
							branch = 1'b1;
							tgt = s_q.ir[11:0];
							do_push = 1'b1;
						end
						`PSC_OPC_RETURN, `PSC_OPC_IRETURN: begin
							branch = 1'b1;
							do_pop = 1'b1;
							tgt = s_q.stk[(s_q.sp == 3'h0) ? 3'h0 : sp_m1];
							if (opc == `PSC_OPC_IRETURN) begin
								s_d.ien = 1'b1;
							end
						end
						`PSC_OPC_SKIP: begin
							case (s_q.ir[9:8])
								2'h0: flush = (s_q.acc == 8'h00);
								2'h1: flush = (s_q.acc != 8'h00);
								2'h2: begin
									s_d.acc = s_q.acc + 8'h01;
									flush = (s_d.acc == 8'h00);
								end
								default: begin
									s_d.acc = s_q.acc - 8'h01;
									flush = (s_d.acc == 8'h00);
								end
							endcase
						end
						default: begin
						end
					endcase
				end
				if (is_alu) begin
					if (opc != `PSC_OPC_ALUP) begin
						s_d.acc = res;
					end
					s_d.z = (res == 8'h00);
					s_d.c = rc;
					s_d.ac = rac;
					s_d.ov = rov;
				end
				if (!branch && !flush && s_q.pclw) begin
					// Low byte write: same page, one dummy cycle.
					branch = 1'b1;
					tgt = {s_q.pc[11:8], s_q.pclv};
					s_d.pclw = 1'b0;
				end
				// A return frees a level, so a held interrupt goes next.
				if (!branch && !flush && s_q.pend && s_q.ien &&
						s_q.sp != `PSC_STACK_DEPTH) begin
					take_int = 1'b1;
					branch = 1'b1;
					do_push = 1'b1;
					tgt = `PSC_INT_VECTOR;
					s_d.ack = 1'b1;
					s_d.ien = 1'b0;
				end
				if (do_push) begin
					// Full stack drops the oldest entry.
					if (s_q.sp == `PSC_STACK_DEPTH) begin
						for (int i = 0; i < 5; i++) begin
							s_d.stk[i] = s_q.stk[i + 1];
						end
						s_d.stk[5] = push_val;
					end else begin
						s_d.stk[s_q.sp] = push_val;
						s_d.sp = s_q.sp + 3'h1;
					end
				end
				if (do_pop && s_q.sp != 3'h0) begin
					s_d.sp = sp_m1;
				end
				if (branch || flush) begin
					// Fetched word is discarded and a dummy cycle runs.
					s_d.ir_v = 1'b0;
					s_d.prog_addr = branch ? tgt : s_q.pc;
				end else begin
					// Overlap: the fetched word executes next cycle.
					s_d.ir = s_q.fetch;
					s_d.ir_v = s_q.fetch_v;
					s_d.prog_addr = s_q.pc;
				end
				s_d.pc = s_d.prog_addr + 12'h001;
			end
		end

		// An arriving request beats the clear of an acknowledge.
		s_d.pend = (s_q.pend && !take_int) || int_req;

		// Only the low byte, control and status are visible; stack is not.
		wr_acc = apb_req.psel && apb_req.penable && apb_req.pwrite;
		rd_acc = apb_req.psel && !apb_req.penable;
		unmapped = apb_req.paddr != `PSC_ADDR_PC_LOW &&
			apb_req.paddr != `PSC_ADDR_CTRL &&
			apb_req.paddr != `PSC_ADDR_STATUS;
		if (wr_acc && apb_req.paddr == `PSC_ADDR_PC_LOW) begin
			s_d.pclw = 1'b1;
			s_d.pclv = apb_req.pwdata[7:0];
		end
		if (wr_acc && apb_req.paddr == `PSC_ADDR_CTRL) begin
			s_d.run = apb_req.pwdata[`PSC_CTRL_RUN];
			s_d.ien = apb_req.pwdata[`PSC_CTRL_IEN];
		end
		if (rd_acc) begin
			case (apb_req.paddr)
				`PSC_ADDR_PC_LOW: s_d.rdata = {24'h000000, s_q.pc[7:0]};
				`PSC_ADDR_CTRL: s_d.rdata = {30'h00000000, s_q.ien, s_q.run};
				`PSC_ADDR_STATUS: s_d.rdata = {13'h0000, s_q.pclw, s_q.pend,
					s_q.phase, s_q.sp, s_q.ov, s_q.ac, s_q.z, s_q.c, s_q.acc};
				default: s_d.rdata = 32'h00000000;
			endcase
		end
	end

	//////////////////////////////////////////////////////////////////////
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
			s_q.phase <= PH_T4;
			s_q.pc <= `PSC_RESET_PC;
			s_q.prog_addr <= `PSC_RESET_PC;
			s_q.sp <= 3'h0;
			s_q.run <= `PSC_CTRL_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	assign prog_addr = s_q.prog_addr;
	assign int_ack = s_q.ack;
	assign apb_rsp.prdata = s_q.rdata;
	assign apb_rsp.pready = 1'b1;
	assign apb_rsp.pslverr = apb_req.psel && apb_req.penable && unmapped;

	//////////////////////////////////////////////////////////////////////
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	logic [11:0] exp_pcl;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			exp_pcl <= 12'h000;
		end else if (wr_acc && apb_req.paddr == `PSC_ADDR_PC_LOW) begin
			exp_pcl <= {s_q.pc[11:8], apb_req.pwdata[7:0]};
		end
	end

	sequence t4_exec(logic [3:0] op);
		s_q.run && s_q.phase == PH_T4 && s_q.ir_v && opc == op &&
			!s_q.pclw;
	endsequence

	sequence dummy_then_fetch;
		!s_q.ir_v ##4 1'b1;
	endsequence

	AST_PHASE_RING: assert property (
		s_q.phase == PH_T1 |=> s_q.phase == PH_T2 ##1 s_q.phase == PH_T3
			##1 s_q.phase == PH_T4 ##1 s_q.phase == PH_T1)
		else $error("phase ring broken");

	AST_PC_AHEAD: assert property (
		s_q.phase == PH_T4 && s_q.run && !s_d.ext |=>
			s_q.pc == s_q.prog_addr + 12'h001)
		else $error("pc not one ahead of fetch address");

	AST_FETCH_T1: assert property (
		s_q.phase == PH_T1 && s_q.run |=> s_q.fetch == $past(prog_rdata))
		else $error("fetch word not captured in first phase");

	AST_JUMP_DUMMY: assert property (
		t4_exec(`PSC_OPC_JUMP) |=> s_q.prog_addr == $past(s_q.ir[11:0])
			and dummy_then_fetch)
		else $error("jump target or dummy cycle wrong");

	AST_EXT_HOLD: assert property (
		t4_exec(`PSC_OPC_XALU) && !s_q.ext |=> s_q.ext && s_q.ir_v
			&& $stable(s_q.prog_addr))
		else $error("extended op did not take a second cycle");

	AST_PC_LOW_JUMP: assert property (
		wr_acc && apb_req.paddr == `PSC_ADDR_PC_LOW && s_q.run
			&& s_q.phase == PH_T1 && !s_q.pclw
			&& !(s_q.ir_v && s_q.ir[15:12] != `PSC_OPC_NOP) |=>
			##[1:4] (s_q.phase == PH_T1 && s_q.prog_addr == exp_pcl
			&& !s_q.ir_v))
		else $error("low byte write did not jump in page");

	AST_FULL_NO_ACK: assert property (
		s_q.sp == `PSC_STACK_DEPTH |-> ##1 !s_q.ack)
		else $error("interrupt acknowledged on full stack");

	AST_CALL_PUSH: assert property (
		t4_exec(`PSC_OPC_CALL) |=>
			s_q.stk[($past(s_q.sp) == 3'h6) ? 3'h5 : $past(s_q.sp)]
			== $past(s_q.prog_addr) && s_q.sp != 3'h0)
		else $error("call did not push the return address");

	AST_RETURN_POP: assert property (
		t4_exec(`PSC_OPC_RETURN) && s_q.sp != 3'h0 |=>
			s_q.sp == $past(sp_m1) && s_q.prog_addr == $past(tgt))
		else $error("return did not pop the stack");

	AST_ZERO_FLAG: assert property (
		t4_exec(`PSC_OPC_ALU) |=> s_q.z == (s_q.acc == 8'h00))
		else $error("zero flag does not follow the result");

endmodule // program_sequencer_core

// ### verif/program_memory_model.sv
/*
 * Partner model: program memory of 4K words and a simple interrupt source.
 * Assumes the sequencer samples the instruction word late in the first
 * phase and takes interrupt requests on pclk.
 */
`timescale 1ns/1ps
module program_memory_model (
	input wire logic pclk,
	input wire logic [11:0] prog_addr,
	output logic [15:0] prog_rdata,
	input wire logic raise,
	output logic int_req
);
	logic [15:0] mem [0:4095];

	initial begin
		int_req = 1'b0;
		for (int i = 0; i < 4096; i++) begin
			mem[i] = 16'h0000;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// The memory answers within the phase, so a plain array read suffices.
	assign prog_rdata = mem[prog_addr];

	// A one-cycle pulse, so the acknowledge edge cannot re-arm a request.
	always @(posedge pclk) begin
		int_req <= raise;
	end
endmodule // program_memory_model

// ### verif/test_program_sequencer_core.sv
/*
 * Self-checking bench of the program sequencer core over APB.
 * Assumes the partner model drives program memory and interrupt requests.
 */
`timescale 1ns/1ps
module test_program_sequencer_core;
	import program_sequencer_core_pkg::*;

	logic pclk;
	logic presetn;
	apb_req_t apb_req;
	apb_rsp_t apb_rsp;
	logic [11:0] prog_addr;
	logic [15:0] prog_rdata;
	logic int_req;
	logic int_ack;
	logic raise;
	int num_errors;
	int tests_run;
	int cyc;
	logic [11:0] tr[$];
	logic [11:0] last;
	logic [31:0] rd;
	logic err;
	logic seen;
	logic [11:0] exp_tr [13] = '{12'h001, 12'h002, 12'h040, 12'h041,
		12'h042, 12'h002, 12'h003, 12'h004, 12'h005, 12'h100, 12'h101,
		12'h102, 12'h101};

	program_sequencer_core dut (
		.pclk(pclk),
		.presetn(presetn),
		.apb_req(apb_req),
		.apb_rsp(apb_rsp),
		.prog_addr(prog_addr),
		.prog_rdata(prog_rdata),
		.int_req(int_req),
		.int_ack(int_ack)
	);

	program_memory_model u_mem (
		.pclk(pclk),
		.prog_addr(prog_addr),
		.prog_rdata(prog_rdata),
		.raise(raise),
		.int_req(int_req)
	);

	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string m);
		tests_run++;
		if (got !== exp) begin
			$display("unexpected at %0t: %s got %h", $time, m, got);
			num_errors++;
		end
	endtask

	// One setup cycle, then the access phase until pready is seen high.
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		apb_req.psel <= 1'b1;
		apb_req.penable <= 1'b0;
		apb_req.pwrite <= w;
		apb_req.paddr <= a;
		apb_req.pwdata <= d;
		@(posedge pclk);
		apb_req.penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (apb_rsp.pready !== 1'b1 && n < 50);
		rd = apb_rsp.prdata;
		err = apb_rsp.pslverr;
		apb_req.psel <= 1'b0;
		apb_req.penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic final_report();
		$display("errors %0d, checks %0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// Timeout: the whole sequence needs well under two thousand cycles.
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			final_report();
		end
	end

	always @(posedge pclk) begin
		if (presetn && prog_addr !== last) begin
			tr.push_back(prog_addr);
			last = prog_addr;
		end
	end

	////////////////////////////////////////////////////////////////////////
	initial begin
		presetn = 1'b0;
		apb_req = '0;
		raise = 1'b0;
		num_errors = 0;
		tests_run = 0;
		cyc = 0;
		last = 12'h000;
		@(posedge pclk);
		u_mem.mem[12'h000] = 16'h1f05;
		u_mem.mem[12'h001] = 16'h4040;
		u_mem.mem[12'h002] = 16'h7000;
		u_mem.mem[12'h003] = 16'h1fee;
		u_mem.mem[12'h004] = 16'h3100;
		u_mem.mem[12'h040] = 16'h1205;
		u_mem.mem[12'h041] = 16'h5000;
		u_mem.mem[12'h100] = 16'h1030;
		u_mem.mem[12'h101] = 16'h3101;
		@(posedge pclk);
		chk(32'(prog_addr), 32'h0, "reset address");
		@(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 8'h04, 32'h0);
		chk(rd, 32'h1, "ctrl reset");
		apb(1'b0, 8'h0c, 32'h0);
		chk({31'h0, err}, 32'h1, "unmapped slverr");
		repeat (100) @(posedge pclk);
		for (int i = 0; i < 13; i++) begin
			chk(32'(tr[i]), 32'(exp_tr[i]), "fetch trace");
		end
		apb(1'b0, 8'h08, 32'h0);
		chk({17'h0, rd[14:0]}, 32'h0030, "status after run");
		// Seven interrupts: six fill the stack, the seventh must wait.
		for (int i = 0; i < 7; i++) begin
			apb(1'b1, 8'h04, 32'h3);
			raise <= 1'b1;
			@(posedge pclk);
			raise <= 1'b0;
			seen = 1'b0;
			repeat (40) begin
				@(posedge pclk);
				if (int_ack === 1'b1) seen = 1'b1;
			end
			chk({31'h0, seen}, {31'h0, (i < 6)}, "interrupt ack");
			apb(1'b0, 8'h08, 32'h0);
			chk(32'(rd[14:12]), (i < 6) ? i + 1 : 6, "stack level");
		end
		chk(32'(rd[17]), 32'h1, "request held");
		apb(1'b1, 8'h00, 32'h80);
		seen = 1'b0;
		repeat (40) begin
			@(posedge pclk);
			if (prog_addr === 12'h180) seen = 1'b1;
		end
		chk({31'h0, seen}, 32'h1, "in-page jump");
		final_report();
	end
endmodule // test_program_sequencer_core
